// *** common/gen_timer_params.svh ***
// constants for the general timer module: offsets, fields, resets
// assumes byte addresses on an 8-bit register port, 32-bit data
`ifndef GEN_TIMER_PARAMS_SVH
`define GEN_TIMER_PARAMS_SVH
`define OFF_CFG 8'h00
`define OFF_MODE_A 8'h04
`define OFF_MODE_B 8'h08
`define OFF_CTL 8'h0c
`define OFF_IMR 8'h18
`define OFF_RIS 8'h1c
`define OFF_MIS 8'h20
`define OFF_ICR 8'h24
`define OFF_LOAD_A 8'h28
`define OFF_LOAD_B 8'h2c
`define OFF_MATCH_A 8'h30
`define OFF_MATCH_B 8'h34
`define OFF_PRE_A 8'h38
`define OFF_PRE_B 8'h3c
`define OFF_VAL_A 8'h48
`define OFF_VAL_B 8'h4c
// control bit positions
`define CTL_EN_A 0
`define CTL_STALL_A 1
`define CTL_CLK_EN 4
`define CTL_OTE_A 5
`define CTL_EN_B 8
`define CTL_STALL_B 9
`define CTL_OTE_B 13
`define CTL_W 14
// status bit positions
`define ST_TO_A 0
`define ST_MATCH 3
`define ST_TO_B 8
`define ST_W 9
// reset values
`define HALF_RST 16'hffff
`define PRE_RST 8'h00
`define RTC_FIRST 32'h0000_0001
`define CNT_ZERO 32'h0000_0000
// rtc input clock and tick rate, in hz
`define RTC_IN_HZ 32768
`define RTC_TICK_HZ 1
`endif

// *** common/gen_timer_pkg.sv ***
// types shared by the general timer module and its bench
// assumes gen_timer_params.svh for numeric constants
package gen_timer_pkg;
  typedef enum logic [2:0] {
    CFG_TIMER32 = 3'b000,
    CFG_RTC32 = 3'b001,
    CFG_SPLIT16 = 3'b100
  } cfg_mode_t;

  typedef enum logic [1:0] {
    MODE_ONESHOT = 2'b01,
    MODE_PERIODIC = 2'b10
  } half_mode_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } bus_req_t;
endpackage

// *** hw/general_timer_module.sv ***
// one timer block: two 16-bit halves, 32-bit down timer or rtc up counter
// assumes a single sys_clk domain; debug_halt comes from same-clock logic
// How it works
// - two 16-bit halves, split or joined
// - trigger ORed with other blocks outside
// - reset: halves and loads ffff, prescale 00
// - config 0 timer32, 1 rtc32
// - config 4 selects split 16-bit halves
// - 32-bit mode acts as one timer
// - 32-bit load write fills both halves
// - 32-bit value read returns both halves
// - in 32-bit mode only first half mode picks one-shot
// - count down, reload after zero
// - one-shot stops, clears enable
// - zero sets sticky time-out flag
// - masked flag follows raw when unmasked
// - trigger pulse when trigger enable set
// - load rewrite taken next cycle
// - stall bit freezes during debug halt
// - rtc counts up, first load one
// - 32.768 khz pin divided to 1 hz
// - rtc match rolls count to zero
// - match sets raw and masked flags
// - rtc enable overrides stall bits
`include "gen_timer_params.svh"

module general_timer_module
  import gen_timer_pkg::*;
#(
  parameter int RTC_DIV = `RTC_IN_HZ / `RTC_TICK_HZ
) (
  // clock, reset, enable
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic clk_en,
  // register port
  input wire bus_req_t bus_req,
  output logic [31:0] rd_data_q,
  // pins and system
  input wire logic capture_compare_pin,
  input wire logic debug_halt,
  output logic adc_trig_q,
  output logic irq_q
);
  cfg_mode_t cfg_q;
  half_mode_t mode_a_q, mode_b_q;
  logic [`CTL_W-1:0] ctl_q;
  logic [`ST_W-1:0] imr_q, ris_q, ris_set, ris_clr;
  logic [15:0] ta_q, tb_q, tal_q, tbl_q, tam_q, tbm_q;
  logic [7:0] tap_q, tbp_q;
  logic [2:0] sync_q;
  logic pin_lvl_q;
  logic [31:0] div_q;
  logic pin_rise, tick;
  logic [31:0] cnt32, load32, match32;
  logic split, halt_a, halt_b, run32, run_a, run_b, rtc_run;
  logic to32, to_a, to_b, ev_ta, rtc_step, rtc_match;
  logic w_cfg, w_ctl, w_icr, w_load_a, w_load_b, w_match_a, w_match_b;
  logic clr_en_a, clr_en_b;
  cfg_mode_t new_cfg;

  assign new_cfg = cfg_mode_t'(bus_req.wdata[2:0]);
  assign w_cfg = bus_req.wr && bus_req.addr == `OFF_CFG;
  assign w_ctl = bus_req.wr && bus_req.addr == `OFF_CTL;
  assign w_icr = bus_req.wr && bus_req.addr == `OFF_ICR;
  assign w_load_a = bus_req.wr && bus_req.addr == `OFF_LOAD_A;
  assign w_load_b = bus_req.wr && bus_req.addr == `OFF_LOAD_B;
  assign w_match_a = bus_req.wr && bus_req.addr == `OFF_MATCH_A;
  assign w_match_b = bus_req.wr && bus_req.addr == `OFF_MATCH_B;

  assign cnt32 = {tb_q, ta_q};
  assign load32 = {tbl_q, tal_q};
  assign match32 = {tbm_q, tam_q};
  assign split = cfg_q == CFG_SPLIT16;
  // rtc enable masks both stall bits
  assign halt_a = debug_halt && ctl_q[`CTL_STALL_A] && !ctl_q[`CTL_CLK_EN];
  assign halt_b = debug_halt && ctl_q[`CTL_STALL_B] && !ctl_q[`CTL_CLK_EN];
  assign run32 = cfg_q == CFG_TIMER32 && ctl_q[`CTL_EN_A] && !halt_a;
  assign run_a = split && ctl_q[`CTL_EN_A] && !halt_a;
  assign run_b = split && ctl_q[`CTL_EN_B] && !halt_b;
  assign rtc_run = cfg_q == CFG_RTC32 && ctl_q[`CTL_EN_A] && !halt_a;
  assign to32 = run32 && cnt32 == `CNT_ZERO;
  assign to_a = run_a && ta_q == 16'h0000;
  assign to_b = run_b && tb_q == 16'h0000;
  assign ev_ta = to32 || to_a;
  assign rtc_step = rtc_run && tick;
  assign rtc_match = rtc_step && cnt32 == match32;
  // only the first half's mode decides in 32-bit mode
  assign clr_en_a = ev_ta && mode_a_q == MODE_ONESHOT;
  assign clr_en_b = to_b && mode_b_q == MODE_ONESHOT;

  // pin sync: a rising change counts once stages two and three agree
  assign pin_rise = sync_q[1] == sync_q[2] && sync_q[2] && !pin_lvl_q;
  assign tick = pin_rise && div_q == 32'(RTC_DIV - 1);

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      sync_q <= 3'h0;
      pin_lvl_q <= 1'b0;
    end else if (clk_en) begin
      sync_q <= {sync_q[1:0], capture_compare_pin};
      if (sync_q[1] == sync_q[2]) begin
        pin_lvl_q <= sync_q[2];
      end
    end
  end

  // divider held while stalled, cleared when rtc is off
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      div_q <= 32'h0;
    end else if (clk_en) begin
      if (cfg_q != CFG_RTC32 || !ctl_q[`CTL_EN_A]) begin
        div_q <= 32'h0;
      end else if (rtc_run && pin_rise) begin
        div_q <= tick ? 32'h0 : div_q + 32'h1;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      cfg_q <= CFG_TIMER32;
      mode_a_q <= MODE_ONESHOT;
      mode_b_q <= MODE_ONESHOT;
      imr_q <= '0;
      tap_q <= `PRE_RST;
      tbp_q <= `PRE_RST;
    end else if (clk_en && bus_req.wr) begin
      case (bus_req.addr)
        `OFF_CFG: cfg_q <= new_cfg;
        `OFF_MODE_A: mode_a_q <= half_mode_t'(bus_req.wdata[1:0]);
        `OFF_MODE_B: mode_b_q <= half_mode_t'(bus_req.wdata[1:0]);
        `OFF_IMR: imr_q <= bus_req.wdata[`ST_W-1:0];
        `OFF_PRE_A: tap_q <= bus_req.wdata[7:0];
        `OFF_PRE_B: tbp_q <= bus_req.wdata[7:0];
        default: ;
      endcase
    end
  end

  // hardware clear of an enable wins over a same-cycle write
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      ctl_q <= '0;
    end else if (clk_en) begin
      ctl_q <= (w_ctl ? bus_req.wdata[`CTL_W-1:0] : ctl_q)
        & ~(`CTL_W'(clr_en_a) << `CTL_EN_A) & ~(`CTL_W'(clr_en_b) << `CTL_EN_B);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      tal_q <= `HALF_RST;
      tbl_q <= `HALF_RST;
      tam_q <= `HALF_RST;
      tbm_q <= `HALF_RST;
    end else if (clk_en) begin
      if (w_load_a) begin
        tal_q <= bus_req.wdata[15:0];
        if (!split) begin
          tbl_q <= bus_req.wdata[31:16];
        end
      end else if (w_load_b) begin
        tbl_q <= bus_req.wdata[15:0];
      end
      if (w_match_a) begin
        tam_q <= bus_req.wdata[15:0];
        if (!split) begin
          tbm_q <= bus_req.wdata[31:16];
        end
      end else if (w_match_b) begin
        tbm_q <= bus_req.wdata[15:0];
      end
    end
  end

  // counter halves; the joined modes drive both halves as one
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      ta_q <= `HALF_RST;
      tb_q <= `HALF_RST;
    end else if (clk_en) begin
      if (w_cfg && new_cfg == CFG_RTC32 && cfg_q != CFG_RTC32) begin
        {tb_q, ta_q} <= `RTC_FIRST;
      end else begin
        case (cfg_q)
          CFG_TIMER32: begin
            if (w_load_a) begin
              {tb_q, ta_q} <= bus_req.wdata;
            end else if (to32) begin
              {tb_q, ta_q} <= load32;
            end else if (run32) begin
              {tb_q, ta_q} <= cnt32 - 32'h1;
            end
          end
          CFG_RTC32: begin
            if (rtc_match) begin
              {tb_q, ta_q} <= `CNT_ZERO;
            end else if (rtc_step) begin
              {tb_q, ta_q} <= cnt32 + 32'h1;
            end
          end
          CFG_SPLIT16: begin
            if (w_load_a) begin
              ta_q <= bus_req.wdata[15:0];
            end else if (to_a) begin
              ta_q <= tal_q;
            end else if (run_a) begin
              ta_q <= ta_q - 16'h1;
            end
            if (w_load_b) begin
              tb_q <= bus_req.wdata[15:0];
            end else if (to_b) begin
              tb_q <= tbl_q;
            end else if (run_b) begin
              tb_q <= tb_q - 16'h1;
            end
          end
          default: ;
        endcase
      end
    end
  end

  // sticky flags: a set in the clearing cycle survives
  always_comb begin
    ris_set = '0;
    ris_set[`ST_TO_A] = ev_ta;
    ris_set[`ST_TO_B] = to_b;
    ris_set[`ST_MATCH] = rtc_match;
    ris_clr = w_icr ? bus_req.wdata[`ST_W-1:0] : '0;
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      ris_q <= '0;
    end else if (clk_en) begin
      ris_q <= (ris_q & ~ris_clr) | ris_set;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      irq_q <= 1'b0;
      adc_trig_q <= 1'b0;
    end else if (clk_en) begin
      irq_q <= |(ris_q & imr_q);
      // block-level OR of both halves; chip level ORs the blocks
      adc_trig_q <= (ev_ta && ctl_q[`CTL_OTE_A]) || (to_b && ctl_q[`CTL_OTE_B]);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      rd_data_q <= 32'h0;
    end else if (clk_en) begin
      rd_data_q <= 32'h0;
      if (bus_req.rd) begin
        case (bus_req.addr)
          `OFF_CFG: rd_data_q <= 32'(cfg_q);
          `OFF_MODE_A: rd_data_q <= 32'(mode_a_q);
          `OFF_MODE_B: rd_data_q <= 32'(mode_b_q);
          `OFF_CTL: rd_data_q <= 32'(ctl_q);
          `OFF_IMR: rd_data_q <= 32'(imr_q);
          `OFF_RIS: rd_data_q <= 32'(ris_q);
          `OFF_MIS: rd_data_q <= 32'(ris_q & imr_q);
          `OFF_LOAD_A: rd_data_q <= split ? 32'(tal_q) : load32;
          `OFF_LOAD_B: rd_data_q <= 32'(tbl_q);
          `OFF_MATCH_A: rd_data_q <= split ? 32'(tam_q) : match32;
          `OFF_MATCH_B: rd_data_q <= 32'(tbm_q);
          `OFF_PRE_A: rd_data_q <= 32'(tap_q);
          `OFF_PRE_B: rd_data_q <= 32'(tbp_q);
          `OFF_VAL_A: rd_data_q <= split ? 32'(ta_q) : cnt32;
          `OFF_VAL_B: rd_data_q <= 32'(tb_q);
          default: rd_data_q <= 32'h0;
        endcase
      end
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  // checked on the first edge after release; the default disable hides the reset edge
  reset_values_a: assert property ($fell(reset) |-> ta_q == `HALF_RST
    && tbl_q == `HALF_RST && tap_q == `PRE_RST && ctl_q == '0)
    else $error("reset values wrong");
  cfg_select_a: assert property (clk_en && w_cfg && bus_req.wdata[2:0] == 3'h1
    |=> cfg_q == CFG_RTC32)
    else $error("config write not taken");
  load_concat_a: assert property (clk_en && w_load_a && !split
    |=> tbl_q == $past(bus_req.wdata[31:16]) && tal_q == $past(bus_req.wdata[15:0]))
    else $error("32-bit load split wrong");
  value_read_a: assert property (clk_en && bus_req.rd && bus_req.addr == `OFF_VAL_A
    && !split |=> rd_data_q == $past(cnt32))
    else $error("32-bit value read wrong");
  reload_zero_a: assert property (clk_en && to32 && !w_load_a && !w_cfg
    |=> cnt32 == $past(load32))
    else $error("no reload after zero");
  oneshot_stop_a: assert property (clk_en && to32 && mode_a_q == MODE_ONESHOT
    |=> !ctl_q[`CTL_EN_A] ##1 (!clk_en || !ctl_q[`CTL_EN_A] || $past(w_ctl)))
    else $error("one-shot kept running");
  timeout_flag_a: assert property (clk_en && ev_ta |=> ris_q[`ST_TO_A])
    else $error("time-out flag not set");
  trigger_pulse_a: assert property (clk_en && ev_ta && ctl_q[`CTL_OTE_A]
    |=> adc_trig_q)
    else $error("trigger missing");
  stall_hold_a: assert property (clk_en && cfg_q == CFG_TIMER32 && halt_a
    && !bus_req.wr |=> $stable(cnt32))
    else $error("counter moved while stalled");
  rtc_rollover_a: assert property (clk_en && rtc_match && !w_cfg
    |=> cnt32 == `CNT_ZERO && ris_q[`ST_MATCH])
    else $error("rtc did not roll over");
  irq_level_a: assert property (clk_en && |(ris_q & imr_q) |=> irq_q)
    else $error("interrupt not raised");
  clear_flag_a: assert property (clk_en && w_icr && bus_req.wdata[`ST_TO_A]
    && !ev_ta |=> !ris_q[`ST_TO_A])
    else $error("clear did not clear");
  // a software load beats both reload and decrement
  load_rewrite_a: assert property (clk_en && w_load_a && cfg_q == CFG_TIMER32
    |=> cnt32 == $past(bus_req.wdata))
    else $error("running load not taken");
  split_load_a: assert property (clk_en && w_load_a && split
    |=> tbl_q == $past(tbl_q))
    else $error("split load touched second half");
  rtc_first_a: assert property (clk_en && w_cfg && bus_req.wdata[2:0] == 3'h1
    && cfg_q != CFG_RTC32 |=> cnt32 == `RTC_FIRST)
    else $error("rtc first load wrong");
  // ticks must still count while halted once the rtc enable is set
  rtc_halt_run_a: assert property (clk_en && cfg_q == CFG_RTC32 && ctl_q[`CTL_EN_A]
    && ctl_q[`CTL_CLK_EN] && tick && cnt32 != match32 |=> cnt32 == $past(cnt32) + 32'h1)
    else $error("rtc stalled by halt");
  irq_drop_a: assert property (clk_en && !(|(ris_q & imr_q)) |=> !irq_q)
    else $error("interrupt stuck high");
  trigger_quiet_a: assert property (clk_en && !ev_ta && !to_b |=> !adc_trig_q)
    else $error("trigger without time-out");

  // covers for the main scenarios

  timeout32_c: cover property (clk_en && to32 ##1 clk_en && run32);
  rtc_match_c: cover property (clk_en && rtc_match);
  split_both_c: cover property (clk_en && to_a ##[1:50] clk_en && to_b);
  stall_freeze_c: cover property (clk_en && halt_a && ctl_q[`CTL_EN_A]);
  rtc_halt_c: cover property (clk_en && rtc_step && debug_halt);
endmodule

// *** testbench/tb_top.sv ***
// self-checking bench for the general timer module, reads checked via a queue
// assumes gen_timer_pkg and gen_timer_params.svh are on the search path
`include "gen_timer_params.svh"
module tb_top
  import gen_timer_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  // short divider keeps the rtc scenario brief
  localparam int DIV = 4;
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic clk_en = 1'b1;
  bus_req_t bus_req = '0;
  logic capture_compare_pin = 1'b0;
  logic debug_halt = 1'b0;
  logic [31:0] rd_data_q;
  logic adc_trig_q;
  logic irq_q;
  logic [31:0] exp_q[$];
  logic rd_seen = 1'b0;
  logic pin_run = 1'b0;
  logic [1:0] pin_div = 2'h0;
  int mismatches = 0;
  int checks = 0;
  int n;
  int len;
  logic [31:0] val;

  general_timer_module #(.RTC_DIV(DIV)) i_general_timer_module (
    .sys_clk(sys_clk),
    .reset(reset),
    .clk_en(clk_en),
    .bus_req(bus_req),
    .rd_data_q(rd_data_q),
    .capture_compare_pin(capture_compare_pin),
    .debug_halt(debug_halt),
    .adc_trig_q(adc_trig_q),
    .irq_q(irq_q)
  );

  initial begin
    forever #2.5 sys_clk = ~sys_clk;
  end

  task automatic check_word(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic check_bit(input string what, input logic exp, input logic got);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch %s expected %b seen %b", what, exp, got);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge sys_clk);
    bus_req.wr <= 1'b0;
  endtask

  // expected value is queued before the strobe goes out
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    exp_q.push_back(exp);
    @(posedge sys_clk);
    bus_req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge sys_clk);
    bus_req.rd <= 1'b0;
  endtask

  // sampled on the falling edge, clear of the design's own updates
  task automatic wait_hi(input bit on_irq, input int lim, output int cnt);
    cnt = 0;
    do begin
      @(negedge sys_clk);
      cnt++;
    end while ((on_irq ? irq_q : adc_trig_q) !== 1'b1 && cnt < lim);
    if ((on_irq ? irq_q : adc_trig_q) !== 1'b1) begin
      mismatches++;
      $display("mismatch wait expected 1 seen 0");
      tally_and_finish();
    end
  endtask

  // read data stands only in the cycle after the strobe
  always @(posedge sys_clk) begin
    if (rd_seen) begin
      if (exp_q.size() == 0) begin
        mismatches++;
        $display("mismatch read_queue expected note seen none");
      end else begin
        check_word("read data", exp_q.pop_front(), rd_data_q);
      end
    end
    rd_seen <= bus_req.rd;
  end

  // slow pin clock, stands still until the rtc scenario
  always @(posedge sys_clk) begin
    pin_div <= pin_div + 2'h1;
    if (pin_run && pin_div == 2'h3) begin
      capture_compare_pin <= ~capture_compare_pin;
    end
  end

  initial begin
    n = $urandom(7624);
    repeat (8) @(posedge sys_clk);
    reset <= 1'b0;
    check_bit("irq", 1'b0, irq_q);
    rd(`OFF_LOAD_A, {`HALF_RST, `HALF_RST});
    rd(`OFF_VAL_A, {`HALF_RST, `HALF_RST});
    rd(`OFF_PRE_A, {24'h0, `PRE_RST});
    rd(`OFF_PRE_B, {24'h0, `PRE_RST});
    rd(`OFF_CTL, 32'h0);
    rd(8'h40, 32'h0);
    val = $urandom();
    wr(`OFF_LOAD_A, val);
    rd(`OFF_LOAD_B, {16'h0, val[31:16]});
    rd(`OFF_VAL_A, val);
    wr(`OFF_VAL_A, 32'h0);
    rd(`OFF_VAL_A, val);
    // one-shot with trigger; second half left periodic on purpose
    len = 2 + ($urandom() % 6);
    wr(`OFF_IMR, 32'h1);
    wr(`OFF_MODE_B, 32'h2);
    wr(`OFF_MODE_A, 32'h1);
    wr(`OFF_LOAD_A, 32'(len));
    wr(`OFF_CTL, 32'h21);
    wait_hi(1'b0, 64, n);
    check_word("timeout delay", 32'(len + 2), 32'(n));
    @(negedge sys_clk);
    check_bit("trig pulse", 1'b0, adc_trig_q);
    rd(`OFF_CTL, 32'h20);
    rd(`OFF_VAL_A, 32'(len));
    rd(`OFF_RIS, 32'h1);
    rd(`OFF_MIS, 32'h1);
    check_bit("irq", 1'b1, irq_q);
    wr(`OFF_ICR, 32'h0);
    rd(`OFF_RIS, 32'h1);
    wr(`OFF_ICR, 32'h1);
    rd(`OFF_RIS, 32'h0);
    rd(`OFF_MIS, 32'h0);
    repeat (2) @(negedge sys_clk);
    check_bit("irq", 1'b0, irq_q);
    // periodic, trigger disabled
    wr(`OFF_MODE_A, 32'h2);
    wr(`OFF_CTL, 32'h1);
    repeat (3 * len + 6) begin
      @(negedge sys_clk);
      check_bit("trig off", 1'b0, adc_trig_q);
    end
    rd(`OFF_CTL, 32'h1);
    rd(`OFF_RIS, 32'h1);
    wr(`OFF_CTL, 32'h0);
    wr(`OFF_ICR, 32'h1);
    // stall during debug halt
    debug_halt <= 1'b1;
    wr(`OFF_LOAD_A, 32'h0001_0000);
    wr(`OFF_CTL, 32'h3);
    repeat (10) @(posedge sys_clk);
    rd(`OFF_VAL_A, 32'h0001_0000);
    // halt released: a load while running, read back one decrement later
    debug_halt <= 1'b0;
    wr(`OFF_LOAD_A, 32'h0002_0000);
    rd(`OFF_VAL_A, 32'h0001_ffff);
    wr(`OFF_CTL, 32'h0);
    // split halves take only the low word
    wr(`OFF_CFG, 32'h4);
    wr(`OFF_LOAD_A, 32'habcd_1234);
    rd(`OFF_LOAD_A, 32'h0000_1234);
    rd(`OFF_LOAD_B, 32'h0000_0002);
    // rtc keeps running through the halt despite the stall bit
    wr(`OFF_CFG, 32'h1);
    rd(`OFF_VAL_A, `RTC_FIRST);
    wr(`OFF_MATCH_A, 32'h3);
    wr(`OFF_IMR, 32'h8);
    debug_halt <= 1'b1;
    wr(`OFF_CTL, 32'h13);
    pin_run <= 1'b1;
    wait_hi(1'b1, 1000, n);
    check_bit("rtc rate", 1'b1, n > 80 && n < 130);
    rd(`OFF_RIS, 32'h8);
    rd(`OFF_VAL_A, `CNT_ZERO);
    rd(`OFF_MIS, 32'h8);
    wr(`OFF_ICR, 32'h8);
    rd(`OFF_RIS, 32'h0);
    rd(`OFF_MIS, 32'h0);
    // clock enable low drops the strobe and freezes state
    clk_en <= 1'b0;
    wr(`OFF_IMR, 32'h0);
    clk_en <= 1'b1;
    rd(`OFF_IMR, 32'h8);
    repeat (4) @(posedge sys_clk);
    tally_and_finish();
  end
endmodule
